// [src/lpb_line_printer_buffer.sv]
/*
 Line printer buffer: line memory, tab and code handling, drum row counting,
 hammer pattern output and paper feed control, with a small register port.
 Assumes the character stream is on clk_sys; printer pins are asynchronous.
*/
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module lpb_line_printer_buffer #(
   parameter int NUM_COLUMNS = lpb_pkg::NUM_COLUMNS
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire logic [4:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Character stream from the in-out converter
   input wire logic [5:0] char_data,
   input wire logic char_valid,
   output logic char_ready,
   // Printer and operator pins
   input wire logic drum_char_sync,
   input wire logic drum_rev_sync,
   input wire logic feed_line_pulse,
   input wire logic paper_settling,
   input wire logic manual_reset_btn,
   output logic feed_request,
   output logic [NUM_COLUMNS-1:0] hammer,
   output logic alarm
);

   // Pin synchronisers: meta stage feeds only the sync stage
   logic [4:0] pin_meta;
   logic [4:0] pin_sync;
   logic [4:0] pin_prev;
   logic char_edge;
   logic rev_edge;
   logic line_edge;
   logic settling;
   logic manual_edge;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_meta <= 5'h00;
         pin_sync <= 5'h00;
         pin_prev <= 5'h00;
      end else begin
         pin_meta <= {manual_reset_btn, paper_settling, feed_line_pulse,
                      drum_rev_sync, drum_char_sync};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // Rising edges of the synchronised pulses; settling is taken as a level
   assign char_edge = pin_sync[0] & ~pin_prev[0];
   assign rev_edge = pin_sync[1] & ~pin_prev[1];
   assign line_edge = pin_sync[2] & ~pin_prev[2];
   assign settling = pin_sync[3];
   assign manual_edge = pin_sync[4] & ~pin_prev[4];

   // Configuration registers
   logic [1:0] mode;
   logic double_feed;
   logic [6:0] line_len;
   logic [5:0] page_lines;
   logic [1:0] page_extra;
   logic [6:0] tab_plug [lpb_pkg::TAB_SOCKETS];
   logic [1:0] next_mode;
   logic next_double_feed;
   logic [6:0] next_line_len;
   logic [5:0] next_page_lines;
   logic [1:0] next_page_extra;
   logic [6:0] next_tab_plug [lpb_pkg::TAB_SOCKETS];
   logic [31:0] next_reg_rdata;

   // Main sequence state
   lpb_pkg::lpb_state_e state;
   lpb_pkg::lpb_state_e next_state;
   logic [6:0] pos;
   logic [6:0] next_pos;
   logic [3:0] tab_idx;
   logic [3:0] next_tab_idx;
   logic first_of_line;
   logic next_first_of_line;
   logic [5:0] feed_count;
   logic [5:0] next_feed_count;
   logic stop_seen;
   logic next_stop_seen;
   logic [6:0] feed_left;
   logic [6:0] next_feed_left;
   logic [6:0] line_cnt;
   logic [6:0] next_line_cnt;
   logic [6:0] rows_done;
   logic [6:0] next_rows_done;
   logic [5:0] next_char_counter;
   logic [5:0] next_next_char_counter;
   logic next_alarm;
   logic [NUM_COLUMNS-1:0] next_hammer;

   // Line memory and derived values
   logic [5:0] char_mem [NUM_COLUMNS];
   logic [NUM_COLUMNS-1:0] col_full;
   logic [NUM_COLUMNS-1:0] match;
   logic wr_en;
   logic line_clear;
   logic [6:0] wr_idx;
   logic [6:0] last_pos;
   logic [6:0] page_total;
   logic accept;
   logic programmed_feed_mode;
   logic verbatim;
   logic ctl_decode;

   // Register writes; tab sockets sit at consecutive offsets
   always_comb begin
      next_mode = mode;
      next_double_feed = double_feed;
      next_line_len = line_len;
      next_page_lines = page_lines;
      next_page_extra = page_extra;
      next_tab_plug = tab_plug;
      if (reg_write) begin
         if (reg_addr == lpb_pkg::ADDR_CTRL) begin
            next_mode = reg_wdata[1:0];
            next_double_feed = reg_wdata[lpb_pkg::CTRL_DOUBLE_BIT];
         end else if (reg_addr == lpb_pkg::ADDR_LINE_LEN) begin
            next_line_len = reg_wdata[6:0];
         end else if (reg_addr == lpb_pkg::ADDR_PAGE) begin
            next_page_lines = reg_wdata[5:0];
            next_page_extra = reg_wdata[lpb_pkg::PAGE_EXTRA_LSB +: 2];
         end else if (reg_addr[4] && reg_addr[3:0] != lpb_pkg::TAB_SIXTEENTH) begin
            next_tab_plug[reg_addr[3:0]] = reg_wdata[6:0];
         end
      end
   end

   // Read data valid only in the cycle after the strobe; unmapped reads zero
   always_comb begin
      next_reg_rdata = 32'h0000_0000;
      if (reg_read) begin
         if (reg_addr == lpb_pkg::ADDR_CTRL) begin
            next_reg_rdata[1:0] = mode;
            next_reg_rdata[lpb_pkg::CTRL_DOUBLE_BIT] = double_feed;
         end else if (reg_addr == lpb_pkg::ADDR_LINE_LEN) begin
            next_reg_rdata[6:0] = line_len;
         end else if (reg_addr == lpb_pkg::ADDR_PAGE) begin
            next_reg_rdata[5:0] = page_lines;
            next_reg_rdata[lpb_pkg::PAGE_EXTRA_LSB +: 2] = page_extra;
         end else if (reg_addr == lpb_pkg::ADDR_STATUS) begin
            next_reg_rdata[5:0] = state;
            next_reg_rdata[lpb_pkg::STAT_ALARM_BIT] = alarm;
            next_reg_rdata[lpb_pkg::STAT_STOP_BIT] = stop_seen;
            next_reg_rdata[lpb_pkg::STAT_FEED_BIT] = feed_request;
         end else if (reg_addr == lpb_pkg::ADDR_POSITION) begin
            next_reg_rdata[6:0] = pos;
            next_reg_rdata[lpb_pkg::POSN_TAB_LSB +: 4] = tab_idx;
            next_reg_rdata[lpb_pkg::POSN_LINE_LSB +: 7] = line_cnt;
            next_reg_rdata[lpb_pkg::POSN_ROW_LSB +: 6] = next_char_counter;
         end else if (reg_addr[4] && reg_addr[3:0] != lpb_pkg::TAB_SIXTEENTH) begin
            next_reg_rdata[6:0] = tab_plug[reg_addr[3:0]];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode <= lpb_pkg::MODE_RESET;
         double_feed <= lpb_pkg::DOUBLE_RESET;
         line_len <= lpb_pkg::LINE_LEN_RESET;
         page_lines <= lpb_pkg::PAGE_LINES_RESET;
         page_extra <= lpb_pkg::PAGE_EXTRA_RESET;
         for (int i = 0; i < lpb_pkg::TAB_SOCKETS; i++) begin
            tab_plug[i] <= 7'h00;
         end
         reg_rdata <= 32'h0000_0000;
      end else begin
         mode <= next_mode;
         double_feed <= next_double_feed;
         line_len <= next_line_len;
         page_lines <= next_page_lines;
         page_extra <= next_page_extra;
         tab_plug <= next_tab_plug;
         reg_rdata <= next_reg_rdata;
      end
   end

   // Derived controls
   assign programmed_feed_mode = (mode == lpb_pkg::MODE_PROG);
   assign verbatim = (mode == lpb_pkg::MODE_VERB);
   // Plug value minus one is the last usable position
   assign last_pos = (line_len == 7'h00) ? lpb_pkg::POS_LAST_FULL : line_len - 7'h01;
   // Lines per page plus one to four extra feeds
   assign page_total = {1'b0, page_lines} + {5'h00, page_extra} + 7'h01;
   // Ready drops once the selector passes the end of line
   assign char_ready = (state == lpb_pkg::ST_READ) && (pos <= last_pos);
   assign accept = char_valid && char_ready;
   assign ctl_decode = !verbatim && !(programmed_feed_mode && first_of_line);
   assign wr_idx = pos - 7'h01;
   // Feed request decoded from the one-hot state register
   assign feed_request = (state == lpb_pkg::ST_FEED_PRE) || (state == lpb_pkg::ST_FEED_POST);

   // Column comparators: each column fires on its drum row
   for (genvar c = 0; c < NUM_COLUMNS; c++) begin : g_col
      assign match[c] = col_full[c] && (char_mem[c] == next_char_counter);
   end

   // Sequence next-state logic
   always_comb begin
      next_state = state;
      next_pos = pos;
      next_tab_idx = tab_idx;
      next_first_of_line = first_of_line;
      next_feed_count = feed_count;
      next_stop_seen = stop_seen;
      next_feed_left = feed_left;
      next_line_cnt = line_cnt;
      next_rows_done = rows_done;
      next_next_char_counter = next_char_counter;
      next_alarm = alarm;
      next_hammer = hammer;
      wr_en = 1'b0;
      line_clear = 1'b0;
      // Revolution pulse marks row zero and beats a character pulse
      if (rev_edge) begin
         next_next_char_counter = 6'h00;
      end else if (char_edge) begin
         next_next_char_counter = next_char_counter + 6'h01;
      end
      // Paper position wraps to zero at the top of the next page
      if (line_edge) begin
         if (line_cnt + 7'h01 >= page_total) begin
            next_line_cnt = 7'h00;
         end else begin
            next_line_cnt = line_cnt + 7'h01;
         end
      end
      // Manual reset clears the alarm; a new alarm below still wins
      if (manual_edge) begin
         next_alarm = 1'b0;
      end
      unique case (state)
         lpb_pkg::ST_READ: begin
            next_hammer = '0;
            if (pos > last_pos) begin
               // Selector ran past the end: line complete
               if (programmed_feed_mode && feed_count != 6'h00) begin
                  next_state = lpb_pkg::ST_FEED_PRE;
                  next_feed_left = {1'b0, feed_count};
               end else begin
                  next_state = lpb_pkg::ST_SETTLE;
               end
            end else if (accept) begin
               if (programmed_feed_mode && first_of_line) begin
                  next_feed_count = char_data;
                  next_first_of_line = 1'b0;
               end else if (!ctl_decode) begin
                  // Every code lands in memory, control codes included
                  wr_en = 1'b1;
                  next_pos = pos + 7'h01;
               end else begin
                  case (char_data)
                     lpb_pkg::CODE_CR: begin
                        next_pos = lpb_pkg::POS_EOL;
                     end
                     lpb_pkg::CODE_STOP: begin
                        next_pos = lpb_pkg::POS_EOL;
                        next_stop_seen = 1'b1;
                     end
                     lpb_pkg::CODE_TAB: begin
                        if (tab_idx == lpb_pkg::TAB_SIXTEENTH) begin
                           next_pos = lpb_pkg::POS_EOL;
                        end else if (tab_plug[tab_idx] == 7'h00) begin
                           next_alarm = 1'b1;
                        end else begin
                           next_pos = tab_plug[tab_idx];
                           next_tab_idx = tab_idx + 4'h1;
                        end
                     end
                     lpb_pkg::CODE_SPACE: begin
                        next_pos = pos + 7'h01;
                     end
                     lpb_pkg::CODE_MASTER_SPACE, lpb_pkg::CODE_NOP_A,
                     lpb_pkg::CODE_NOP_B, lpb_pkg::CODE_NOP_C: begin
                        next_pos = pos;
                     end
                     default: begin
                        wr_en = 1'b1;
                        next_pos = pos + 7'h01;
                     end
                  endcase
               end
            end
         end
         lpb_pkg::ST_FEED_PRE, lpb_pkg::ST_FEED_POST: begin
            next_hammer = '0;
            if (line_edge) begin
               next_feed_left = feed_left - 7'h01;
               if (feed_left <= 7'h01) begin
                  // Enough lines counted: request drops next cycle
                  if (state == lpb_pkg::ST_FEED_PRE) begin
                     next_state = lpb_pkg::ST_SETTLE;
                  end else if (stop_seen) begin
                     next_state = lpb_pkg::ST_HALT;
                  end else begin
                     next_state = lpb_pkg::ST_READ;
                  end
               end
            end
         end
         lpb_pkg::ST_SETTLE: begin
            next_hammer = '0;
            // Paper still moving: hold off the print pass
            if (!settling) begin
               next_state = lpb_pkg::ST_PRINT;
               next_rows_done = 7'h00;
            end
         end
         lpb_pkg::ST_PRINT: begin
            if (char_edge && rows_done > lpb_pkg::ROWS_LAST) begin
               // Pulse after the 64th row: the last row has had its full
               // strike, so the feed never starts under a live hammer
               next_hammer = '0;
               line_clear = 1'b1;
               next_pos = lpb_pkg::POS_FIRST;
               next_tab_idx = 4'h0;
               next_first_of_line = 1'b1;
               next_feed_count = 6'h00;
               next_state = lpb_pkg::ST_FEED_POST;
               if (stop_seen) begin
                  next_feed_left = page_total - line_cnt;
               end else if (verbatim) begin
                  next_feed_left = lpb_pkg::FEED_DOUBLE;
               end else if (programmed_feed_mode) begin
                  next_state = lpb_pkg::ST_READ;
               end else if (double_feed) begin
                  next_feed_left = lpb_pkg::FEED_DOUBLE;
               end else begin
                  next_feed_left = lpb_pkg::FEED_SINGLE;
               end
            end else if (char_edge) begin
               next_hammer = match;
               next_rows_done = rows_done + 7'h01;
            end
         end
         lpb_pkg::ST_HALT: begin
            next_hammer = '0;
            if (manual_edge) begin
               next_state = lpb_pkg::ST_READ;
               next_stop_seen = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= lpb_pkg::ST_READ;
         pos <= lpb_pkg::POS_FIRST;
         tab_idx <= 4'h0;
         first_of_line <= 1'b1;
         feed_count <= 6'h00;
         stop_seen <= 1'b0;
         feed_left <= 7'h00;
         line_cnt <= 7'h00;
         rows_done <= 7'h00;
         next_char_counter <= 6'h00;
         alarm <= 1'b0;
         hammer <= '0;
      end else begin
         state <= next_state;
         pos <= next_pos;
         tab_idx <= next_tab_idx;
         first_of_line <= next_first_of_line;
         feed_count <= next_feed_count;
         stop_seen <= next_stop_seen;
         feed_left <= next_feed_left;
         line_cnt <= next_line_cnt;
         rows_done <= next_rows_done;
         next_char_counter <= next_next_char_counter;
         alarm <= next_alarm;
         hammer <= next_hammer;
      end
   end

   // Line memory; occupancy bits keep empty columns from firing
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         char_mem[wr_idx] <= char_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || line_clear) begin
         col_full <= '0;
      end else if (wr_en) begin
         col_full[wr_idx] <= 1'b1;
      end
   end

   // Checks on the sequence
   AST_FEED_AFTER_PRINT: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(feed_request) |->
      ($past(state) == lpb_pkg::ST_PRINT && $past(rows_done) > lpb_pkg::ROWS_LAST) ||
      ($past(state) == lpb_pkg::ST_READ && $past(programmed_feed_mode)))
      else $error("feed request rose before the line was done");

   AST_SETTLE_HOLDS_PRINT: assert property (@(posedge clk_sys) disable iff (rst)
      (state == lpb_pkg::ST_SETTLE && settling) |=> (state != lpb_pkg::ST_PRINT))
      else $error("print started while paper settling");

   AST_ROW_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
      (char_edge && !rev_edge) |=> (next_char_counter == $past(next_char_counter) + 6'h01))
      else $error("row counter did not advance");

   AST_REV_ALIGN: assert property (@(posedge clk_sys) disable iff (rst)
      rev_edge |=> (next_char_counter == 6'h00))
      else $error("revolution pulse did not realign row counter");

   AST_TAB_SIXTEEN: assert property (@(posedge clk_sys) disable iff (rst)
      (accept && ctl_decode && char_data == lpb_pkg::CODE_TAB && tab_idx == 4'hf)
      |=> (pos == lpb_pkg::POS_EOL) ##1 (state != lpb_pkg::ST_READ))
      else $error("sixteenth tab did not end the line");

   AST_EMPTY_TAB: assert property (@(posedge clk_sys) disable iff (rst)
      (accept && ctl_decode && char_data == lpb_pkg::CODE_TAB && tab_idx != 4'hf
       && tab_plug[tab_idx] == 7'h00) |=> alarm && $stable(pos))
      else $error("empty tab socket did not raise alarm");

   AST_SPACE_STEP: assert property (@(posedge clk_sys) disable iff (rst)
      (accept && ctl_decode && char_data == lpb_pkg::CODE_SPACE)
      |-> !wr_en ##1 (pos == $past(pos) + 7'h01))
      else $error("space did not advance the selector");

   AST_CR_ENDS_READ: assert property (@(posedge clk_sys) disable iff (rst)
      (accept && ctl_decode && char_data == lpb_pkg::CODE_CR) |=> !char_ready ##1
      (state == lpb_pkg::ST_SETTLE || state == lpb_pkg::ST_FEED_PRE))
      else $error("carriage return did not end read-in");

   AST_HALT_WAITS: assert property (@(posedge clk_sys) disable iff (rst)
      (state == lpb_pkg::ST_HALT && !manual_edge) |=> (state == lpb_pkg::ST_HALT) && !feed_request)
      else $error("halt left without manual reset");

   AST_FEED_END: assert property (@(posedge clk_sys) disable iff (rst)
      (feed_request && line_edge && feed_left <= 7'h01) |=> !feed_request)
      else $error("feed request held past the counted lines");

endmodule

`default_nettype wire

// [src/lpb_pkg.sv]
/*
 Constants, register map and state encoding for the line printer buffer.
 Assumes one 125 MHz system clock and a plain register port with 5-bit addresses.
*/
package lpb_pkg;

   // Geometry
   localparam int NUM_COLUMNS = 120;
   localparam int TAB_SOCKETS = 15;
   localparam logic [6:0] POS_FIRST = 7'h01;
   localparam logic [6:0] POS_LAST_FULL = 7'h78;
   localparam logic [6:0] POS_EOL = 7'h79;
   localparam logic [6:0] ROWS_LAST = 7'h3f;
   localparam logic [3:0] TAB_SIXTEENTH = 4'hf;

   // Character codes
   localparam logic [5:0] CODE_MASTER_SPACE = 6'h00;
   localparam logic [5:0] CODE_NOP_A = 6'h01;
   localparam logic [5:0] CODE_NOP_B = 6'h02;
   localparam logic [5:0] CODE_TAB = 6'h03;
   localparam logic [5:0] CODE_CR = 6'h04;
   localparam logic [5:0] CODE_SPACE = 6'h05;
   localparam logic [5:0] CODE_STOP = 6'h2f;
   localparam logic [5:0] CODE_NOP_C = 6'h3f;

   // Modes
   localparam logic [1:0] MODE_AUTO = 2'h0;
   localparam logic [1:0] MODE_PROG = 2'h1;
   localparam logic [1:0] MODE_VERB = 2'h2;

   // Feed amounts
   localparam logic [6:0] FEED_SINGLE = 7'h01;
   localparam logic [6:0] FEED_DOUBLE = 7'h02;

   // Register offsets
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_LINE_LEN = 5'h01;
   localparam logic [4:0] ADDR_PAGE = 5'h02;
   localparam logic [4:0] ADDR_STATUS = 5'h03;
   localparam logic [4:0] ADDR_POSITION = 5'h04;
   localparam logic [4:0] ADDR_TAB_BASE = 5'h10;

   // Field positions
   localparam int CTRL_DOUBLE_BIT = 2;
   localparam int PAGE_EXTRA_LSB = 6;
   localparam int STAT_ALARM_BIT = 8;
   localparam int STAT_STOP_BIT = 9;
   localparam int STAT_FEED_BIT = 10;
   localparam int POSN_TAB_LSB = 8;
   localparam int POSN_LINE_LSB = 16;
   localparam int POSN_ROW_LSB = 24;

   // Reset values
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic DOUBLE_RESET = 1'b0;
   localparam logic [6:0] LINE_LEN_RESET = 7'h00;
   localparam logic [5:0] PAGE_LINES_RESET = 6'h3c;
   localparam logic [1:0] PAGE_EXTRA_RESET = 2'h1;

   // Main sequence
   typedef enum logic [5:0] {
      ST_READ = 6'h01,
      ST_FEED_PRE = 6'h02,
      ST_SETTLE = 6'h04,
      ST_PRINT = 6'h08,
      ST_FEED_POST = 6'h10,
      ST_HALT = 6'h20
   } lpb_state_e;

endpackage

// [dv/lpb_printer_model.sv]
/*
 Behavioural drum printer: free running drum rows, paper feed and settling.
 Assumes the drum turns at one row per 16 clk_sys cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module lpb_printer_model (
   // Clock
   input wire logic clk_sys,
   // Printer pins
   input wire logic feed_request,
   output logic drum_char_sync,
   output logic drum_rev_sync,
   output logic feed_line_pulse,
   output logic paper_settling,
   // Observation
   output logic [5:0] row,
   output logic [3:0] ph,
   output var int fed
);
   logic [4:0] fph;
   int settle;
   initial begin
      row = 6'h00;
      ph = 4'h0;
      fph = 5'h00;
      fed = 0;
      settle = 0;
   end
   // Drum never stops, so row pulses run outside print too
   always @(posedge clk_sys) begin
      ph <= ph + 4'h1;
      if (ph == 4'hf) row <= row + 6'h01;
   end
   assign drum_char_sync = (ph < 4'h2);
   assign drum_rev_sync = (row == 6'h3f) && (ph inside {4'h8, 4'h9});
   // Paper moves while requested; one pulse per line, then slow to rest
   always @(posedge clk_sys) begin
      fph <= feed_request ? fph + 5'h01 : 5'h00;
      if (feed_request && fph == 5'h1b) fed <= fed + 1;
      settle <= feed_request ? 40 : (settle > 0 ? settle - 1 : 0);
   end
   assign feed_line_pulse = feed_request && (fph >= 5'h1c);
   assign paper_settling = feed_request || (settle > 0);
endmodule
`default_nettype wire

// [dv/tb_top.sv]
/*
 Self-checking bench for the line printer buffer.
 Assumes the printer model on the far side and the register port on clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk_sys = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, char_valid = 1'b0;
   logic manual_reset_btn = 1'b0, mon_on = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [5:0] char_data = 6'h00, row;
   logic [3:0] ph;
   wire logic [31:0] reg_rdata;
   wire logic char_ready, dcs, drs, flp, settling, feed_request, alarm;
   wire logic [119:0] hammer;
   logic [119:0] exp [64], seen, want;
   int failures = 0, n_checks = 0, fed, fed0;
   always #4 clk_sys = ~clk_sys;
   lpb_line_printer_buffer uut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .char_data(char_data), .char_valid(char_valid), .char_ready(char_ready),
      .drum_char_sync(dcs), .drum_rev_sync(drs), .feed_line_pulse(flp),
      .paper_settling(settling), .manual_reset_btn(manual_reset_btn),
      .feed_request(feed_request), .hammer(hammer), .alarm(alarm));
   lpb_printer_model mdl (.clk_sys(clk_sys), .feed_request(feed_request), .drum_char_sync(dcs),
      .drum_rev_sync(drs), .feed_line_pulse(flp), .paper_settling(settling), .row(row),
      .ph(ph), .fed(fed));
   task give_verdict;
      if (failures == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task check(input logic [119:0] got, input logic [119:0] want_v);
      n_checks++;
      if (got !== want_v) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want_v);
      end
   endtask
   task wr(input logic [4:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task rd(input logic [4:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 check({88'h0, reg_rdata}, {88'h0, e});
      @(posedge clk_sys);
   endtask
   // Expected hammer rows per drum code
   task clr;
      for (int i = 0; i < 64; i++) exp[i] = '0;
      want = '0;
   endtask
   task put(input logic [5:0] code, input int col);
      exp[code][col] = 1'b1;
      want[col] = 1'b1;
   endtask
   // Valid held across characters; ready judged at the falling edge, where it is settled
   task send(input logic [23:0] cs, input int n);
      fed0 = fed;
      seen = '0;
      for (int i = 0; i < n; i++) begin
         char_data <= cs[6*(n-1-i) +: 6];
         char_valid <= 1'b1;
         @(negedge clk_sys);
         while (char_ready !== 1'b1) @(negedge clk_sys);
         @(posedge clk_sys);
      end
      char_valid <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   task line(input logic [23:0] cs, input int n, input int nf);
      send(cs, n);
      @(negedge clk_sys);
      while (char_ready !== 1'b1) @(negedge clk_sys);
      @(posedge clk_sys);
      check(seen, want);
      check(120'(fed - fed0), 120'(nf));
   endtask
   task pulse_manual;
      manual_reset_btn <= 1'b1;
      repeat (6) @(posedge clk_sys);
      manual_reset_btn <= 1'b0;
      repeat (6) @(posedge clk_sys);
   endtask
   // Stop: print, feed to the page top, then hold until the manual reset
   task stop_page(input int nf);
      clr();
      put(6'h06, 0);
      send({12'h0, 6'h06, lpb_pkg::CODE_STOP}, 2);
      @(negedge feed_request);
      repeat (60) @(posedge clk_sys);
      check({119'h0, char_ready}, 120'h0);
      check(seen, want);
      check(120'(fed - fed0), 120'(nf));
      pulse_manual();
      check({119'h0, char_ready}, 120'h1);
   endtask
   // Hammer must show only the row now under the hammers, never while paper moves
   always @(posedge clk_sys) begin
      #1;
      if (mon_on) begin
         seen = seen | hammer;
         if (hammer !== '0 && ph > 4'h5) check(hammer, exp[row]);
         if (settling && hammer !== '0) check(hammer, '0);
      end
   end
   initial begin
      #200000;
      failures++;
      give_verdict();
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      mon_on <= 1'b1;
      @(posedge clk_sys);
      rd(lpb_pkg::ADDR_CTRL, 32'h0);
      rd(lpb_pkg::ADDR_PAGE, 32'h7c);
      rd(lpb_pkg::ADDR_STATUS, 32'h1);
      rd(5'h1f, 32'h0);
      // Row counter is only aligned once the first revolution pulse has passed
      while (!(row == 6'h3f && ph == 4'hf)) @(posedge clk_sys);
      clr();
      put(6'h06, 0);
      put(6'h07, 2);
      line({6'h06, 6'h05, 6'h07, 6'h04}, 4, 1);
      wr(lpb_pkg::ADDR_TAB_BASE, 32'h0a);
      clr();
      put(6'h06, 9);
      line({6'h03, 6'h06, 6'h03, 6'h04}, 4, 1);
      check({119'h0, alarm}, 120'h1);
      pulse_manual();
      check({119'h0, alarm}, 120'h0);
      wr(lpb_pkg::ADDR_CTRL, {30'h0, lpb_pkg::MODE_PROG});
      clr();
      put(6'h06, 0);
      line({6'h00, 6'h02, 6'h06, 6'h04}, 3, 2);
      wr(lpb_pkg::ADDR_LINE_LEN, 32'h3);
      wr(lpb_pkg::ADDR_CTRL, {30'h0, lpb_pkg::MODE_VERB});
      clr();
      put(6'h04, 0);
      put(6'h03, 1);
      line({12'h0, 6'h04, 6'h03}, 2, 2);
      wr(lpb_pkg::ADDR_LINE_LEN, 32'h0);
      wr(lpb_pkg::ADDR_CTRL, {30'h0, lpb_pkg::MODE_AUTO});
      // Six lines fed so far; a page is lines plus extra plus one
      stop_page(int'(lpb_pkg::PAGE_LINES_RESET) + int'(lpb_pkg::PAGE_EXTRA_RESET) - 5);
      give_verdict();
   end
endmodule
`default_nettype wire
